// [sds_sequencer.sv]
// Functional notes
// [R1] Forward start to CPU after start delay.
// [R2] Each delay uses its own 7-bit setting.
// [R3] Binary weights; delay is sum of set bits.
// [R4] Per-delay unit select; default seconds, value one.
// [R5] Auxiliary outputs change after delay from start.
// [R6] Capacitor outputs change after delay from bypass.
// [R7] Delayed relay follows command after start delay.
// [R8] Immediate relay follows command without delay.
// [R9] Emergency bypass holds CPU off, start closes isolation.
// [R10] Emergency indication while bypass input closed.
// [R11] Fuse relay operates on blown fuse or open disconnect.
// [R12] Fault relay changes on any fault condition.
// [R13] Opening either interlock means shutdown.
// [R14] Customer supplies two-wire or three-wire start logic.
// [R15] At-speed taken from bypass contactor auxiliary contact.
// [R16] Drive isolation and bypass coils in sequence.
// [R17] LEDs: start, fault, fuse, capacitor, auxiliary.
// [R18] Board delays add to CPU setpoint, never replace.
// [R19] Dual adjust switch enables feature; other unused.
// [R20] Units: mains period or one second.
// [R21] Three-wire start latch cleared by stop, interlock, fault.
module sds_sequencer
  import sds_pkg::*;
#(
  parameter int unsigned SEC_COUNT = SEC_CYCLES
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [3:0]    adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic      [31:0]   dat_o,
  output logic               ack_o,
  input  wire sds_contacts_t contacts_i,
  output sds_drives_t        drives_o,
  output sds_leds_t          leds_o
);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  function automatic logic unit_is_sec(input logic [MODE_W-1:0] mode,
                                       input int unsigned       idx);
    // Seconds jumper wins; with neither jumper fitted, cycles are used.
    return mode[MODE_SEC_LSB + idx];
  endfunction : unit_is_sec

  // Weighted sum of the switch positions; position k is worth 2**k units.
  function automatic logic [DLY_W-1:0] switch_units(
      input logic [DLY_W-1:0] sw);
    logic [DLY_W-1:0] acc;
    acc = '0;
    for (int k = 0; k < DLY_W; k++) begin
      if (sw[k]) begin
        acc = acc + (DLY_W'(1) << k);
      end
    end
    return acc;
  endfunction : switch_units

  function automatic logic [DLY_W-1:0] delay_field(input logic [31:0] word,
                                                    input int          idx);
    return word[idx*DLY_FIELD_STRIDE +: DLY_W];
  endfunction : delay_field

  function automatic logic [31:0] read_select(input logic [3:0]  adr,
                                              input logic [31:0] delay_w,
                                              input logic [31:0] mode_w,
                                              input logic [31:0] status_w);
    logic [31:0] r;
    unique case (adr)
      ADR_DELAY:  r = delay_w;
      ADR_MODE:   r = mode_w;
      ADR_STATUS: r = status_w;
      default:    r = '0;
    endcase
    return r;
  endfunction : read_select

  logic [DLY_W-1:0]   dly_set_r [NUM_DLY];
  logic [MODE_W-1:0]  mode_r;
  logic [DLY_W-1:0]   dly_cnt_r [NUM_DLY];
  logic [NUM_DLY-1:0] dly_done_r;
  logic [31:0]        sec_div_r;
  logic               sec_tick_r;
  logic               run_latch_r;
  logic               at_speed_r;
  sds_state_t         state_r;
  sds_state_t         state_nxt;
  logic               ack_r;
  logic [31:0]        dat_r;
  sds_drives_t        drv_r;
  sds_drives_t        drv_nxt;
  sds_leds_t          led_r;
  sds_leds_t          led_nxt;

  wire logic        bus_req   = cyc_i & stb_i & ~ack_r;
  wire logic        wr_delay  = bus_req & we_i & (adr_i == ADR_DELAY);
  wire logic        wr_mode   = bus_req & we_i & (adr_i == ADR_MODE);
  wire logic [31:0] delay_rd  = {9'h000, dly_set_r[DLY_CAP],
                                 1'b0, dly_set_r[DLY_AUX],
                                 1'b0, dly_set_r[DLY_START]};
  wire logic [31:0] delay_wr  = merge_bytes(delay_rd, dat_i, sel_i);
  wire logic [31:0] mode_wr   = merge_bytes({23'h000000, mode_r},
                                            dat_i, sel_i);

  wire logic interlocks_ok = contacts_i.shutdown_a_closed &
                             contacts_i.shutdown_b_closed; // R13
  wire logic fuse_blown    = ~contacts_i.fuse_ok_closed; // R11
  wire logic any_fault     = fuse_blown | ~contacts_i.overload_ok_closed |
                             contacts_i.cpu_fault; // R12
  wire logic permissive    = interlocks_ok & ~any_fault;
  wire logic three_wire    = mode_r[MODE_THREE];
  wire logic run_latch_nxt = permissive & contacts_i.stop_closed &
                             (run_latch_r | contacts_i.start_closed); // R21
  // Two-wire: maintained contact; three-wire: latched push-buttons. R14
  wire logic run_cmd       = three_wire ? run_latch_r
                                        : (permissive &
                                           contacts_i.start_closed);
  wire logic emerg         = contacts_i.emerg_bypass_closed;
  // Normally-closed bypass auxiliary opens once the bypass has pulled in.
  wire logic at_speed_nxt  = ~contacts_i.bypass_aux_closed &
                             drv_r.bypass_coil; // R15
  wire logic [NUM_DLY-1:0] dly_arm = {at_speed_r & ~emerg, run_cmd,
                                      run_cmd}; // R5 R6
  wire logic [NUM_DLY-1:0] dly_tick;
  wire logic [DLY_W-1:0]   dly_target [NUM_DLY];
  wire logic               sec_wrap = (sec_div_r == SEC_COUNT - 1);

  for (genvar g = 0; g < NUM_DLY; g++) begin : g_tick
    assign dly_tick[g] = unit_is_sec(mode_r, g) ? sec_tick_r
                                                : contacts_i.line_tick; // R20
    assign dly_target[g] = switch_units(dly_set_r[g]); // R3
  end

  // The CPU stays out of the sequence while the emergency input is closed.
  wire logic normal_run  = (state_r == SDS_NORMAL) & run_cmd & ~emerg; // R9
  wire logic start_fwd   = normal_run & dly_done_r[DLY_START];
  wire logic iso_nxt     = run_cmd & (state_nxt != SDS_IDLE);
  wire logic bypass_nxt  = normal_run & contacts_i.cpu_bypass_req;
  wire logic delayed_nxt = run_cmd & dly_done_r[DLY_START];
  wire logic aux_nxt     = run_cmd & dly_done_r[DLY_AUX];
  wire logic cap_nxt     = dly_arm[DLY_CAP] & dly_done_r[DLY_CAP];

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SDS_IDLE: begin
        if (run_cmd) begin
          state_nxt = emerg ? SDS_EMERG : SDS_NORMAL;
        end
      end
      SDS_NORMAL, SDS_EMERG: begin
        if (!run_cmd) begin
          state_nxt = SDS_IDLE;
        end
      end
      default: begin
        state_nxt = SDS_IDLE;
      end
    endcase
  end

  always_comb begin
    drv_nxt                 = '0;
    drv_nxt.cpu_hold_off    = emerg; // R9
    drv_nxt.immediate_relay = run_cmd; // R8
    drv_nxt.delayed_relay   = delayed_nxt; // R7
    // CPU applies its own start setpoint on top of this delay. R18
    drv_nxt.cpu_start       = start_fwd; // R1
    drv_nxt.iso_coil        = iso_nxt; // R16 R9
    drv_nxt.bypass_coil     = bypass_nxt; // R16
    drv_nxt.aux_relay       = aux_nxt; // R5
    drv_nxt.cap_relay       = cap_nxt; // R6
    drv_nxt.fault_relay     = any_fault; // R12
    drv_nxt.fuse_relay      = fuse_blown; // R11
    drv_nxt.emerg_relay     = emerg; // R10
    drv_nxt.dual_adjust     = mode_r[MODE_DUAL]; // R19
  end

  always_comb begin
    led_nxt.led_start = run_cmd; // R17
    led_nxt.led_fault = any_fault;
    led_nxt.led_fuse  = fuse_blown;
    led_nxt.led_cap   = cap_nxt;
    led_nxt.led_aux   = aux_nxt;
  end

  // Free-running divider, so the first unit after arming may be short.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_div_r <= '0;
    end else begin
      sec_div_r <= sec_wrap ? '0 : sec_div_r + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_tick_r <= 1'b0;
    end else begin
      sec_tick_r <= sec_wrap;
    end
  end

  // Count whole units while armed; done when count reaches the target. R3
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NUM_DLY; i++) begin
      if (rst_i || !dly_arm[i]) begin
        dly_cnt_r[i]  <= '0;
        dly_done_r[i] <= 1'b0;
      end else if (dly_cnt_r[i] >= dly_target[i]) begin
        dly_done_r[i] <= 1'b1; // R2
      end else if (dly_tick[i]) begin
        dly_cnt_r[i] <= dly_cnt_r[i] + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_DLY; i++) begin
        dly_set_r[i] <= DLY_RST; // R4
      end
    end else if (wr_delay) begin
      for (int i = 0; i < NUM_DLY; i++) begin
        dly_set_r[i] <= delay_field(delay_wr, i); // R2
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= MODE_RST; // R4
    end else if (wr_mode) begin
      mode_r <= mode_wr[MODE_W-1:0];
    end
  end

  wire logic [31:0] mode_rd   = {23'h000000, mode_r};
  wire logic [31:0] status_rd = {13'h0000, state_r, at_speed_r, run_cmd,
                                 dly_done_r, drv_r};
  wire logic [31:0] read_nxt  = read_select(adr_i, delay_rd, mode_rd,
                                            status_rd);

  // A request is answered on the next edge; ack_r masks it meanwhile.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
    end
  end

  // Read data holds the last value read until the next read.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= '0;
    end else if (bus_req && !we_i) begin
      dat_r <= read_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= SDS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_latch_r <= 1'b0;
    end else begin
      run_latch_r <= run_latch_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      at_speed_r <= 1'b0;
    end else begin
      at_speed_r <= at_speed_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drv_r <= '0;
    end else begin
      drv_r <= drv_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      led_r <= '0;
    end else begin
      led_r <= led_nxt;
    end
  end

  assign dat_o    = dat_r;
  assign ack_o    = ack_r;
  assign drives_o = drv_r;
  assign leds_o   = led_r;

endmodule : sds_sequencer

// [sds_pkg.sv]
package sds_pkg;

  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SEC_NS        = 1_000_000_000;
  localparam int unsigned SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;

  localparam int unsigned DLY_W    = 7;
  localparam int unsigned NUM_DLY  = 3;
  localparam int unsigned DLY_START = 0;
  localparam int unsigned DLY_AUX   = 1;
  localparam int unsigned DLY_CAP   = 2;

  localparam logic [3:0] ADR_DELAY  = 4'h0;
  localparam logic [3:0] ADR_MODE   = 4'h4;
  localparam logic [3:0] ADR_STATUS = 4'h8;

  localparam int unsigned DLY_FIELD_STRIDE = 8;
  localparam logic [DLY_W-1:0] DLY_RST = 7'h01;

  localparam int unsigned MODE_CYC_LSB  = 0;
  localparam int unsigned MODE_SEC_LSB  = 3;
  localparam int unsigned MODE_THREE    = 6;
  localparam int unsigned MODE_DUAL     = 7;
  localparam int unsigned MODE_UNUSED   = 8;
  localparam int unsigned MODE_W        = 9;
  localparam logic [MODE_W-1:0] MODE_RST = 9'h038;

  typedef enum logic [1:0] {
    SDS_IDLE,
    SDS_NORMAL,
    SDS_EMERG
  } sds_state_t;

  typedef struct packed {
    logic shutdown_a_closed;
    logic shutdown_b_closed;
    logic stop_closed;
    logic start_closed;
    logic emerg_bypass_closed;
    logic fuse_ok_closed;
    logic overload_ok_closed;
    logic bypass_aux_closed;
    logic line_tick;
    logic cpu_fault;
    logic cpu_bypass_req;
  } sds_contacts_t;

  typedef struct packed {
    logic cpu_start;
    logic cpu_hold_off;
    logic iso_coil;
    logic bypass_coil;
    logic immediate_relay;
    logic delayed_relay;
    logic aux_relay;
    logic cap_relay;
    logic fault_relay;
    logic fuse_relay;
    logic emerg_relay;
    logic dual_adjust;
  } sds_drives_t;

  typedef struct packed {
    logic led_start;
    logic led_fault;
    logic led_fuse;
    logic led_cap;
    logic led_aux;
  } sds_leds_t;

endpackage : sds_pkg

// [sds_properties.sv]
module sds_properties
  import sds_pkg::*;
#(parameter int unsigned SEC_COUNT = SEC_CYCLES) (
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          cyc_i,
  input wire logic          stb_i,
  input wire logic          we_i,
  input wire logic [3:0]    adr_i,
  input wire logic [3:0]    sel_i,
  input wire logic [31:0]   dat_i,
  input wire logic [31:0]   dat_o,
  input wire logic          ack_o,
  input wire sds_contacts_t contacts_i,
  input wire sds_drives_t   drives_o,
  input wire sds_leds_t     leds_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_pulse; ack_o |=> !ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_emrg; contacts_i.emerg_bypass_closed |=> drives_o.emerg_relay;
  endproperty
  a_emrg: assert property (p_emrg) else $error("no bypass flag");
  property p_hold;
    drives_o.cpu_hold_off |-> !drives_o.cpu_start && !drives_o.bypass_coil;
  endproperty
  a_hold: assert property (p_hold) else $error("cpu not held");
  property p_fuse; !contacts_i.fuse_ok_closed |=> drives_o.fuse_relay;
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse relay idle");
  property p_ovl; !contacts_i.overload_ok_closed |=> drives_o.fault_relay;
  endproperty
  a_ovl: assert property (p_ovl) else $error("fault relay idle");
  property p_shut;
    !(contacts_i.shutdown_a_closed && contacts_i.shutdown_b_closed) [*4]
      |-> !drives_o.cpu_start;
  endproperty
  a_shut: assert property (p_shut) else $error("run in shutdown");
  property p_cpu; $rose(drives_o.cpu_start) |-> drives_o.immediate_relay;
  endproperty
  a_cpu: assert property (p_cpu) else $error("start without cmd");
  property p_led; $rose(drives_o.fuse_relay) |-> ##[0:1] leds_o.led_fuse;
  endproperty
  a_led: assert property (p_led) else $error("fuse led idle");
  c_cap: cover property (drives_o.cap_relay);
  c_aux: cover property (drives_o.aux_relay);
  c_emg: cover property (drives_o.emerg_relay && drives_o.iso_coil);
endmodule : sds_properties

bind sds_sequencer sds_properties #(.SEC_COUNT(SEC_COUNT)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .contacts_i(contacts_i), .drives_o(drives_o), .leds_o(leds_o));

// [sds_cpu_model.sv]
module sds_cpu_model
  import sds_pkg::*;
#(parameter int RAMP = 5, parameter int LT = 8) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        fault_i,
  input  wire sds_drives_t drv_i,
  output logic             req_o,
  output logic             aux_nc_o,
  output logic             tick_o,
  output logic             fault_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int ramp_r;
  int tick_r;
  // The ramp adds its own time on top of the board's start delay.
  always_ff @(posedge clk_i) begin
    ramp_r   <= (rst_i || !drv_i.cpu_start) ? 0 : ramp_r + 1;
    tick_r   <= (rst_i || tick_r == LT - 1) ? 0 : tick_r + 1;
    req_o    <= !rst_i && ramp_r >= RAMP;
    aux_nc_o <= !drv_i.bypass_coil;
    tick_o   <= !rst_i && tick_r == LT - 1;
    fault_o  <= fault_i;
  end
endmodule : sds_cpu_model

// [sds_tb_top.sv]
module sds_tb_top
  import sds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned SC = 10;
  logic          clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, flt;
  logic          m_req, m_aux, m_tick, m_flt;
  logic [3:0]    adr_i, sel_i;
  logic [31:0]   dat_i, dat_o, q;
  sds_contacts_t ct, contacts;
  sds_drives_t   drives_o;
  sds_leds_t     leds_o;
  int            err_total, num_checks;
  assign contacts = {ct[10:4], m_aux, m_tick, m_flt, m_req};
  sds_sequencer #(.SEC_COUNT(SC)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .contacts_i(contacts),
    .drives_o(drives_o), .leds_o(leds_o));
  sds_cpu_model cpu_u (.clk_i(clk_i), .rst_i(rst_i), .fault_i(flt),
    .drv_i(drives_o), .req_o(m_req), .aux_nc_o(m_aux), .tick_o(m_tick),
    .fault_o(m_flt));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hf};
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 50);
    chk(ack_o, 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask : wb
  task t_regs;
    chk(drives_o, 12'h000);
    wb(1'b0, ADR_DELAY, 32'h0);
    chk(q, 32'h00010101);
    wb(1'b0, ADR_MODE, 32'h0);
    chk(q, 32'h00000038);
    wb(1'b1, 4'hc, 32'hffffffff);
    wb(1'b0, 4'hc, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, ADR_MODE, 32'h0000009c);
    wb(1'b1, ADR_DELAY, 32'h00020503);
    wb(1'b0, ADR_DELAY, 32'h0);
    chk(q, 32'h00020503);
    chk(drives_o.dual_adjust, 1);
  endtask : t_regs
  task t_run;
    int n, ts, ta, tb, tc;
    {ts, ta, tb, tc} = '0;
    @(posedge clk_i);
    ct.start_closed <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk({drives_o.immediate_relay, drives_o.iso_coil}, 2'b11);
    for (n = 1; n < 200; n++) begin
      @(negedge clk_i);
      if (!ts && drives_o.cpu_start) ts = n;
      if (!ta && drives_o.aux_relay) ta = n;
      if (!tb && drives_o.bypass_coil) tb = n;
      if (!tc && drives_o.cap_relay) tc = n;
    end
    chk(ts >= 2 * SC && ts <= 3 * SC + 4, 1);
    chk(drives_o.delayed_relay, 1);
    chk(ta >= 4 * SC && ta <= 5 * SC + 4, 1);
    chk(tb > ts && tc - tb >= 8 && tc - tb <= 22, 1);
    chk({leds_o.led_start, leds_o.led_cap, leds_o.led_aux}, 3'b111);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk(q[18:12], 7'h3f);
    @(posedge clk_i);
    ct.emerg_bypass_closed <= 1'b1;
    repeat (3) @(negedge clk_i);
    chk({drives_o.cpu_start, drives_o.bypass_coil, drives_o.iso_coil},
        3'b001);
    @(posedge clk_i);
    ct.emerg_bypass_closed <= 1'b0;
    @(posedge clk_i);
    ct.start_closed <= 1'b0;
    repeat (4) @(negedge clk_i);
    chk(drives_o[11:8], 4'h0);
  endtask : t_run
  task t_fault;
    int i;
    @(posedge clk_i);
    ct.start_closed <= 1'b1;
    for (i = 0; i < 5; i++) begin
      @(posedge clk_i);
      ct.fuse_ok_closed <= (i != 0);
      ct.overload_ok_closed <= (i != 1);
      flt <= (i == 2);
      ct.shutdown_a_closed <= (i != 3);
      ct.shutdown_b_closed <= (i != 4);
      repeat (4) @(negedge clk_i);
      chk({drives_o.iso_coil, drives_o.fault_relay, drives_o.fuse_relay},
          {1'b0, 1'(i < 3), 1'(i == 0)});
      chk(leds_o.led_fault, 1'(i < 3));
    end
    @(posedge clk_i);
    ct <= 11'h730;
    repeat (4) @(negedge clk_i);
    chk(drives_o.fault_relay, 0);
  endtask : t_fault
  task t_emerg;
    @(posedge clk_i);
    ct.emerg_bypass_closed <= 1'b1;
    repeat (3) @(negedge clk_i);
    chk({drives_o.emerg_relay, drives_o.cpu_hold_off}, 2'b11);
    @(posedge clk_i);
    ct.start_closed <= 1'b1;
    repeat (60) @(negedge clk_i);
    chk({drives_o.iso_coil, drives_o.cpu_start}, 2'b10);
    @(posedge clk_i);
    ct <= 11'h730;
  endtask : t_emerg
  task t_three;
    wb(1'b1, ADR_MODE, 32'h000000dc);
    ct.start_closed <= 1'b1;
    repeat (2) @(posedge clk_i);
    ct.start_closed <= 1'b0;
    repeat (4) @(negedge clk_i);
    chk(drives_o.immediate_relay, 1);
    @(posedge clk_i);
    ct.stop_closed <= 1'b0;
    repeat (4) @(negedge clk_i);
    chk(drives_o.immediate_relay, 0);
  endtask : t_three
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    {err_total, num_checks} = '0;
    ct = 11'h730;
    flt = 1'b0;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_run;
    t_fault;
    t_emerg;
    t_three;
    print_verdict;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    print_verdict;
  end
endmodule : sds_tb_top
